//--- src/irq_pkg.sv
// constants and types of the interrupt mask and flag block
package irq_pkg;
    // register offsets
    localparam logic [7:0] OFS_MISC_IRQ_MASK     = 8'h04;
    localparam logic [7:0] OFS_SUPPLY_IRQ_FLAGS  = 8'h05;
    localparam logic [7:0] OFS_MISC_IRQ_FLAGS    = 8'h06;
    localparam logic [7:0] OFS_SUPPLY_FAULT_MASK = 8'h07;
    // values after reset, and the value read at unmapped offsets
    localparam logic [7:0] RST_MISC_IRQ_MASK     = 8'h00;
    localparam logic [7:0] RST_SUPPLY_FAULT_MASK = 8'h00;
    localparam logic [7:0] RST_FLAGS             = 8'h00;
    localparam logic [7:0] RD_UNMAPPED           = 8'h00;
    // device bus address, value arbitrary
    localparam logic [6:0] DEV_ADDR              = 7'h48;
    // bits in one serial byte
    localparam logic [3:0] BYTE_BITS             = 4'h8;
    // bit positions in the misc mask and flags
    localparam int BIT_CONV_DONE  = 7;
    localparam int BIT_AIN_HIZ    = 6;
    localparam int BIT_PIN2_EDGE  = 5;
    localparam int BIT_PIN1_EDGE  = 4;
    localparam int BIT_THERMAL    = 3;
    localparam int BIT_CHARGER    = 2;
    localparam int BIT_CONV_ABOVE = 1;
    localparam int BIT_CONV_BELOW = 0;
    // serial port states, nine of them need four bits
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WR, ST_WR_ACK, ST_RD,
        ST_MST_ACK
    } port_state_t;
endpackage

//--- src/sync2.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,   // register clock
    input  wire logic         rstn,  // asynchronous reset, active low
    input  wire logic [W-1:0] d,     // asynchronous levels
    output logic      [W-1:0] q      // synchronised levels
);
    logic [W-1:0] meta_r;  // first stage, read only by the second

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

//--- src/flag_cell.sv
// one flag: set by unmasked event, cleared by host write of 0
`timescale 1ns/1ps
module flag_cell (
    input  wire logic clk,      // register clock
    input  wire logic rstn,     // asynchronous reset, active low
    input  wire logic evt,      // source event in this cycle
    input  wire logic mask,     // 1 blocks the source
    input  wire logic cap_en,   // flags may be set
    input  wire logic wr,       // host write to this flag's register
    input  wire logic wbit,     // written bit value
    output logic      flag_r    // flag state
);
    logic flag_nxt;  // next flag value

    // set has priority over the host clear
    always_comb begin
        flag_nxt = flag_r;
        if (wr && !wbit) begin
            flag_nxt = 1'b0;
        end
        // R02 mask gates source
        if (cap_en && evt && !mask) begin
            flag_nxt = 1'b1;
        end
    end

    // flag storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule

//--- src/irq_mask_ack_regs.sv
// interrupt mask and acknowledge registers with their two-wire register port
//
// Notes on behaviour
// R01 - misc mask holds eight event source masks
// R02 - mask 0 passes source, 1 blocks it
// R03 - supply flag register shows faulting supply
// R04 - flag 1 means cause; host writes 0
// R05 - misc flag register is read-only status; here a host write of 0 clears its bits
// R06 - unmasked pin edges set flag, raise request
// R07 - unmasked conversion done sets flag, raises request
// R08 - unmasked input high impedance sets flag
// R09 - above and below limits set own flags
// R10 - fault mask excludes supplies from fault
// R11 - flags set first, then line goes low
// R12 - flags frozen while request line low
// R13 - host clears cause, line returns high
// R14 - unmasked supply fault regardless of line
`timescale 1ns/1ps
module irq_mask_ack_regs (
    input  wire logic       clk,                  // register clock
    input  wire logic       rstn,                 // asynchronous reset, active low
    input  wire logic       scl,                  // serial clock pin
    input  wire logic       sda_in,               // serial data pin level
    output logic            sda_out,              // serial data drive value
    output logic            sda_oe_n,             // data enable, low drives
    output logic            int_n,                // request to host, active low
    output logic            supply_fault,         // power-good fault, active high
    input  wire logic [7:0] supply_in_regulation, // per supply, 1 = output good
    input  wire logic [7:0] supply_irq_mask,      // first source mask, 1 blocks
    input  wire logic       conv_done,            // conversion complete pulse
    input  wire logic       conv_above,           // sample above high limit pulse
    input  wire logic       conv_below,           // sample below low limit pulse
    input  wire logic [1:0] charger_state_bits,   // charger status bits
    input  wire logic       analog_in_hiz,        // input high impedance level
    input  wire logic       thermal_fault,        // thermal fault level
    input  wire logic       gp_pin_one,           // general-purpose pin 1
    input  wire logic       gp_pin_two            // general-purpose pin 2
);
    // synchronised pin and comparator levels
    logic [7:0]  supply_ok_s;      // supplies in regulation
    logic        scl_s;            // serial clock
    logic        sda_s;            // serial data
    logic        pin1_s;           // pin 1
    logic        pin2_s;           // pin 2
    logic        hiz_s;            // analog input high impedance
    logic        therm_s;          // thermal fault
    // previous levels for edge detection
    logic        scl_d_r;          // serial clock last cycle
    logic        sda_d_r;          // serial data last cycle
    logic        pin1_d_r;         // pin 1 last cycle
    logic        pin2_d_r;         // pin 2 last cycle
    logic        hiz_d_r;          // high impedance last cycle
    logic        therm_d_r;        // thermal last cycle
    logic [1:0]  chg_d_r;          // charger bits last cycle
    // register state
    logic [7:0]  misc_mask_r;      // misc source masks
    logic [7:0]  misc_mask_nxt;
    logic [7:0]  fault_mask_r;     // supply fault masks
    logic [7:0]  fault_mask_nxt;
    logic        int_n_r;          // request line
    logic        int_n_nxt;
    logic        fault_r;          // supply fault output
    logic        fault_nxt;
    logic [15:0] flags;            // supply flags high, misc flags low
    logic [15:0] evt;              // event per flag
    logic [15:0] msk;              // mask per flag
    logic        cap_en;           // flags may take new events
    // serial port state
    irq_pkg::port_state_t st_r;    // protocol state
    irq_pkg::port_state_t st_nxt;
    logic [3:0]  cnt_r;            // bits received in this byte
    logic [3:0]  cnt_nxt;
    logic [7:0]  sh_r;             // shift register
    logic [7:0]  sh_nxt;
    logic [7:0]  ptr_r;            // register pointer
    logic [7:0]  ptr_nxt;
    logic        drv_r;            // 1 pulls the data line low
    logic        drv_nxt;
    logic        rw_r;             // transfer is a read
    logic        rw_nxt;
    logic        wr_stb;           // register write strobe
    logic [7:0]  rd_byte;          // addressed register
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;

    // pins and comparators pass two flops
    sync2 #(.W(14)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({supply_in_regulation, scl, sda_in, gp_pin_one, gp_pin_two,
                analog_in_hiz, thermal_fault}),
        .q    ({supply_ok_s, scl_s, sda_s, pin1_s, pin2_s, hiz_s, therm_s})
    );

    // delayed copies of the synchronised levels except the supplies, and of the raw charger bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_d_r   <= 1'b1;
            sda_d_r   <= 1'b1;
            pin1_d_r  <= 1'b0;
            pin2_d_r  <= 1'b0;
            hiz_d_r   <= 1'b0;
            therm_d_r <= 1'b0;
            chg_d_r   <= 2'h0;
        end else begin
            scl_d_r   <= scl_s;
            sda_d_r   <= sda_s;
            pin1_d_r  <= pin1_s;
            pin2_d_r  <= pin2_s;
            hiz_d_r   <= hiz_s;
            therm_d_r <= therm_s;
            chg_d_r   <= charger_state_bits;
        end
    end

    // bus conditions seen on the synchronised lines
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;

    // event sources, misc byte in mask bit order
    always_comb begin
        evt = 16'h0000;
        // R03 supply out of regulation
        evt[15:8] = ~supply_ok_s;
        // R07 conversion done
        evt[irq_pkg::BIT_CONV_DONE]  = conv_done;
        // R08 high impedance detected
        evt[irq_pkg::BIT_AIN_HIZ]    = hiz_s && !hiz_d_r;
        // R06 either edge on pins
        evt[irq_pkg::BIT_PIN2_EDGE]  = pin2_s ^ pin2_d_r;
        evt[irq_pkg::BIT_PIN1_EDGE]  = pin1_s ^ pin1_d_r;
        evt[irq_pkg::BIT_THERMAL]    = therm_s && !therm_d_r;
        evt[irq_pkg::BIT_CHARGER]    = charger_state_bits != chg_d_r;
        // R09 limit crossings
        evt[irq_pkg::BIT_CONV_ABOVE] = conv_above;
        evt[irq_pkg::BIT_CONV_BELOW] = conv_below;
    end

    // R01 misc mask bit order
    assign msk    = {supply_irq_mask, misc_mask_r};
    // R12 latch while request pending
    assign cap_en = flags == 16'h0000;

    // one flag cell per acknowledge bit
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            // R04 write 0 clears flag
            flag_cell u_flag (
                .clk    (clk),
                .rstn   (rstn),
                .evt    (evt[gi]),
                .mask   (msk[gi]),
                .cap_en (cap_en),
                .wr     (wr_stb && (ptr_r == ((gi >= 8) ? irq_pkg::OFS_SUPPLY_IRQ_FLAGS
                                                         : irq_pkg::OFS_MISC_IRQ_FLAGS))),
                .wbit   (sh_r[gi % 8]),
                .flag_r (flags[gi])
            );
        end
    endgenerate

    // mask registers, request line and fault output
    always_comb begin
        misc_mask_nxt  = misc_mask_r;
        fault_mask_nxt = fault_mask_r;
        if (wr_stb && ptr_r == irq_pkg::OFS_MISC_IRQ_MASK) begin
            misc_mask_nxt = sh_r;
        end
        // R10 fault mask write
        if (wr_stb && ptr_r == irq_pkg::OFS_SUPPLY_FAULT_MASK) begin
            fault_mask_nxt = sh_r;
        end
        // R11 line follows flags
        // R13 all flags clear releases
        int_n_nxt = cap_en;
        // R14 independent of request line
        fault_nxt = |(~supply_ok_s & ~fault_mask_r);
    end

    // register state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            misc_mask_r  <= irq_pkg::RST_MISC_IRQ_MASK;
            fault_mask_r <= irq_pkg::RST_SUPPLY_FAULT_MASK;
            int_n_r      <= 1'b1;
            fault_r      <= 1'b0;
        end else begin
            misc_mask_r  <= misc_mask_nxt;
            fault_mask_r <= fault_mask_nxt;
            int_n_r      <= int_n_nxt;
            fault_r      <= fault_nxt;
        end
    end

    assign int_n        = int_n_r;
    assign supply_fault = fault_r;

    // read mux; unmapped offsets read as zero
    always_comb begin
        unique case (ptr_r)
            irq_pkg::OFS_MISC_IRQ_MASK:     rd_byte = misc_mask_r;
            irq_pkg::OFS_SUPPLY_IRQ_FLAGS:  rd_byte = flags[15:8];
            // R05 misc flags as status
            irq_pkg::OFS_MISC_IRQ_FLAGS:    rd_byte = flags[7:0];
            irq_pkg::OFS_SUPPLY_FAULT_MASK: rd_byte = fault_mask_r;
            default:                        rd_byte = irq_pkg::RD_UNMAPPED;
        endcase
    end

    // serial port: address, pointer, data bytes with auto-increment
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        sh_nxt  = sh_r;
        ptr_nxt = ptr_r;
        drv_nxt = drv_r;
        rw_nxt  = rw_r;
        wr_stb  = 1'b0;
        if (start_c) begin
            // start or repeated start, pointer kept for reads
            st_nxt  = irq_pkg::ST_ADDR;
            cnt_nxt = 4'h0;
            drv_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt  = irq_pkg::ST_IDLE;
            drv_nxt = 1'b0;
        end else begin
            unique case (st_r)
                irq_pkg::ST_IDLE: begin
                    drv_nxt = 1'b0;
                end
                irq_pkg::ST_ADDR, irq_pkg::ST_PTR, irq_pkg::ST_WR: begin
                    if (scl_rise && cnt_r != irq_pkg::BYTE_BITS) begin
                        sh_nxt  = {sh_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == irq_pkg::BYTE_BITS) begin
                        drv_nxt = 1'b1;
                        if (st_r == irq_pkg::ST_ADDR) begin
                            // foreign address: off the bus until start
                            if (sh_r[7:1] == irq_pkg::DEV_ADDR) begin
                                rw_nxt = sh_r[0];
                                st_nxt = irq_pkg::ST_ADDR_ACK;
                            end else begin
                                drv_nxt = 1'b0;
                                st_nxt  = irq_pkg::ST_IDLE;
                            end
                        end else if (st_r == irq_pkg::ST_PTR) begin
                            ptr_nxt = sh_r;
                            st_nxt  = irq_pkg::ST_PTR_ACK;
                        end else begin
                            // only a complete byte is written
                            wr_stb  = 1'b1;
                            ptr_nxt = ptr_r + 8'h01;
                            st_nxt  = irq_pkg::ST_WR_ACK;
                        end
                    end
                end
                irq_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (rw_r) begin
                            sh_nxt  = rd_byte;
                            drv_nxt = !rd_byte[7];
                            st_nxt  = irq_pkg::ST_RD;
                        end else begin
                            drv_nxt = 1'b0;
                            st_nxt  = irq_pkg::ST_PTR;
                        end
                    end
                end
                irq_pkg::ST_PTR_ACK, irq_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        drv_nxt = 1'b0;
                        st_nxt  = irq_pkg::ST_WR;
                    end
                end
                irq_pkg::ST_RD: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == irq_pkg::BYTE_BITS) begin
                        // release for host acknowledge
                        drv_nxt = 1'b0;
                        ptr_nxt = ptr_r + 8'h01;
                        st_nxt  = irq_pkg::ST_MST_ACK;
                    end else if (scl_fall) begin
                        sh_nxt  = {sh_r[6:0], 1'b0};
                        drv_nxt = !sh_r[6];
                    end
                end
                irq_pkg::ST_MST_ACK: begin
                    if (scl_rise && sda_s) begin
                        // host nack ends the read
                        st_nxt = irq_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        sh_nxt  = rd_byte;
                        drv_nxt = !rd_byte[7];
                        st_nxt  = irq_pkg::ST_RD;
                    end
                end
            endcase
        end
    end

    // serial port state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r  <= irq_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            sh_r  <= 8'h00;
            ptr_r <= 8'h00;
            drv_r <= 1'b0;
            rw_r  <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r  <= sh_nxt;
            ptr_r <= ptr_nxt;
            drv_r <= drv_nxt;
            rw_r  <= rw_nxt;
        end
    end

    // open drain, pulls low only
    assign sda_out  = 1'b0;
    assign sda_oe_n = !drv_r;
endmodule

//--- verification/irq_regs_sva.sv
// port-level checks for the interrupt mask and acknowledge block
`timescale 1ns/1ps
module irq_regs_chk (
    input  wire logic       clk,                  // register clock
    input  wire logic       rstn,                 // reset
    input  wire logic       scl,                  // serial clock
    input  wire logic       sda_in,               // data line level
    input  wire logic       sda_oe_n,             // data enable
    input  wire logic       int_n,                // request line
    input  wire logic       supply_fault,         // fault output
    input  wire logic [7:0] supply_in_regulation, // supply good
    input  wire logic [7:0] supply_irq_mask,      // supply mask
    input  wire logic       conv_done,            // conversion pulse
    input  wire logic       conv_above,           // above limit pulse
    input  wire logic       conv_below,           // below limit pulse
    input  wire logic [1:0] charger_state_bits,   // charger bits
    input  wire logic       analog_in_hiz,        // hiz level
    input  wire logic       thermal_fault,        // thermal level
    input  wire logic       gp_pin_one,           // pin 1
    input  wire logic       gp_pin_two            // pin 2
);
    logic [3:0]  cyc_r;     // cycles since reset
    logic [3:0]  cyc_nxt;   // next count
    logic [3:0]  quiet_r;   // quiet cycles
    logic [3:0]  quiet_nxt; // next count
    logic [13:0] evt;       // event inputs now
    logic [13:0] evt_r;     // event inputs one cycle ago
    logic        sup_ok;    // every supply in regulation
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    assign evt = {charger_state_bits, analog_in_hiz, thermal_fault, gp_pin_one, gp_pin_two,
                  supply_irq_mask};
    assign sup_ok = &supply_in_regulation;
    // saturating, so no false quiet period after a wrap
    always_comb begin
        cyc_nxt = (cyc_r == 4'hf) ? cyc_r : cyc_r + 4'h1;
        quiet_nxt = 4'h0;
        // pulses count as movement
        if (evt == evt_r && !(conv_done | conv_above | conv_below) && sup_ok) begin
            quiet_nxt = (quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1;
        end
    end
    // helper counter registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc_r <= 4'h0;
            quiet_r <= 4'h0;
            evt_r <= '0;
        end else begin
            cyc_r <= cyc_nxt;
            quiet_r <= quiet_nxt;
            evt_r <= evt;
        end
    end
    a_rst_release: assert property ($past(!rstn) |-> int_n && sda_oe_n)
        else $error("outputs not idle after reset");
    a_int_quiet_hold: assert property (quiet_r >= 4'h8 |-> !$fell(int_n))
        else $error("request raised with no event");
    a_int_rise_write: assert property ($rose(int_n) |-> !scl && !$past(scl, 3))
        else $error("request released outside a write");
    a_int_idle_bus: assert property (scl [*8] ##1 scl |-> !$rose(int_n))
        else $error("request released on an idle bus");
    a_fault_ok_low: assert property (cyc_r >= 4'h5 && $past(sup_ok, 2) && $past(sup_ok, 3)
        && $past(sup_ok, 4) |-> !supply_fault)
        else $error("fault with all supplies good");
    a_fault_rise_cause: assert property ($rose(supply_fault) && cyc_r >= 4'h5
        |-> !($past(sup_ok, 2) && $past(sup_ok, 3) && $past(sup_ok, 4)))
        else $error("fault rose with no supply loss");
    a_sda_drive_low: assert property ($changed(sda_oe_n) |-> !scl && !$past(scl, 2))
        else $error("data drive moved while clock high");
    a_start_free: assert property (scl && $past(scl) && $fell(sda_in) |-> sda_oe_n)
        else $error("device drove data during a start");
endmodule
bind irq_mask_ack_regs irq_regs_chk chk (
    .clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
    .int_n(int_n), .supply_fault(supply_fault), .supply_in_regulation(supply_in_regulation),
    .supply_irq_mask(supply_irq_mask), .conv_done(conv_done), .conv_above(conv_above),
    .conv_below(conv_below), .charger_state_bits(charger_state_bits),
    .analog_in_hiz(analog_in_hiz), .thermal_fault(thermal_fault),
    .gp_pin_one(gp_pin_one), .gp_pin_two(gp_pin_two)
);

//--- verification/wire_host.sv
// two-wire host model for the device's register port
`timescale 1ns/1ps
module wire_host (
    input  wire logic clk,      // register clock
    input  wire logic sda_oe_n, // device pulls low at 0
    output logic      scl,      // serial clock
    output logic      sda_in    // resolved data line
);
    logic       drv; // 1 releases
    logic       ack; // ninth bit, 0 = ack
    logic [7:0] rx;  // last byte seen
    // open drain line with pull-up
    assign sda_in = drv & sda_oe_n;
    initial begin
        scl = 1'b1;
        drv = 1'b1;
    end
    // half bit period
    task automatic hb();
        repeat (10) @(negedge clk);
    endtask
    // start or repeated start
    task automatic start();
        drv = 1'b1;
        hb();
        scl = 1'b1;
        hb();
        drv = 1'b0;
        hb();
        scl = 1'b0;
    endtask
    task automatic stop();
        drv = 1'b0;
        hb();
        scl = 1'b1;
        hb();
        drv = 1'b1;
        hb();
    endtask
    // byte msb first, then ninth bit m
    task automatic xfer(input logic [7:0] b, input logic m);
        for (int i = 7; i >= -1; i--) begin
            drv = (i < 0) ? m : b[i[2:0]];
            hb();
            scl = 1'b1;
            hb();
            if (i >= 0) begin
                rx[i[2:0]] = sda_in;
            end else begin
                ack = sda_in;
            end
            scl = 1'b0;
        end
    endtask
endmodule

//--- verification/irq_mask_ack_regs_tb_top.sv
// self-checking bench for the interrupt mask and acknowledge block
`timescale 1ns/1ps
module irq_mask_ack_regs_tb_top;
    logic       clk = 1'b0;                // clock
    logic       rstn = 1'b0;               // reset
    logic       scl;                       // serial clock
    logic       sda_in;                    // data line
    logic       sda_out;                   // drive value
    logic       sda_oe_n;                  // drive enable
    logic       int_n;                     // request line
    logic       supply_fault;              // fault output
    logic [7:0] supply_in_regulation = 8'hff; // supplies good
    logic [7:0] supply_irq_mask = 8'hff;   // masked during reset
    logic       conv_done = 1'b0;          // conversion pulse
    logic       conv_above = 1'b0;         // above limit pulse
    logic       conv_below = 1'b0;         // below limit pulse
    logic [1:0] charger_state_bits = 2'h0; // charger bits
    logic       analog_in_hiz = 1'b0;      // hiz level
    logic       thermal_fault = 1'b0;      // thermal level
    logic       gp_pin_one = 1'b0;         // pin 1
    logic       gp_pin_two = 1'b0;         // pin 2
    logic [7:0] rdat;                      // last byte read
    int         n_errors = 0;              // mismatches
    int         check_count = 0;           // comparisons
    always #25 clk = ~clk;
    wire_host h (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_in(sda_in));
    irq_mask_ack_regs dut (
        .clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .int_n(int_n), .supply_fault(supply_fault),
        .supply_in_regulation(supply_in_regulation), .supply_irq_mask(supply_irq_mask),
        .conv_done(conv_done), .conv_above(conv_above), .conv_below(conv_below),
        .charger_state_bits(charger_state_bits), .analog_in_hiz(analog_in_hiz),
        .thermal_fault(thermal_fault), .gp_pin_one(gp_pin_one), .gp_pin_two(gp_pin_two)
    );
    task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp_bit(input string n, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", n, e, s);
        end
    endtask
    // pointer then data byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        h.start();
        h.xfer({irq_pkg::DEV_ADDR, 1'b0}, 1'b1);
        h.xfer(a, 1'b1);
        h.xfer(d, 1'b1);
        cmp_bit("data ack", 1'b0, h.ack);
        h.stop();
    endtask
    // pointer, repeated start, one byte, nack
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        h.start();
        h.xfer({irq_pkg::DEV_ADDR, 1'b0}, 1'b1);
        h.xfer(a, 1'b1);
        h.start();
        h.xfer({irq_pkg::DEV_ADDR, 1'b1}, 1'b1);
        h.xfer(8'hff, 1'b1);
        rdat = h.rx;
        h.stop();
        cmp_byte("reg", e, rdat);
    endtask
    // one event on misc source i
    task automatic fire(input int i);
        @(negedge clk);
        case (i)
            7: conv_done = 1'b1;
            6: analog_in_hiz = 1'b1;
            5: gp_pin_two = ~gp_pin_two;
            4: gp_pin_one = ~gp_pin_one;
            3: thermal_fault = 1'b1;
            2: charger_state_bits = charger_state_bits + 2'h1;
            1: conv_above = 1'b1;
            default: conv_below = 1'b1;
        endcase
        @(negedge clk);
        {conv_done, conv_above, conv_below} = 3'h0;
        repeat (4) @(negedge clk);
        {analog_in_hiz, thermal_fault} = 2'h0;
        repeat (6) @(negedge clk);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        cmp_bit("int_n", 1'b1, int_n);
        cmp_bit("sda_out", 1'b0, sda_out);
        for (int a = 4; a < 9; a++) chk_rd(8'(a), 8'h00);
        h.start();
        h.xfer({irq_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b1);
        cmp_bit("foreign addr", 1'b1, h.ack);
        h.stop();
        wr(irq_pkg::OFS_MISC_IRQ_MASK, 8'ha5);
        chk_rd(irq_pkg::OFS_MISC_IRQ_MASK, 8'ha5);
        wr(irq_pkg::OFS_SUPPLY_FAULT_MASK, 8'h3c);
        chk_rd(irq_pkg::OFS_SUPPLY_FAULT_MASK, 8'h3c);
        wr(irq_pkg::OFS_MISC_IRQ_FLAGS, 8'hff);
        chk_rd(irq_pkg::OFS_MISC_IRQ_FLAGS, 8'h00);
        supply_irq_mask = 8'h00;
        for (int i = 0; i < 8; i++) begin
            wr(irq_pkg::OFS_MISC_IRQ_MASK, 8'h00);
            fire(i);
            cmp_bit("int_n", 1'b0, int_n);
            fire((i + 1) % 8);
            chk_rd(irq_pkg::OFS_MISC_IRQ_FLAGS, 8'h01 << i);
            chk_rd(irq_pkg::OFS_SUPPLY_IRQ_FLAGS, 8'h00);
            wr(irq_pkg::OFS_MISC_IRQ_FLAGS, 8'h00);
            cmp_bit("int_n", 1'b1, int_n);
            wr(irq_pkg::OFS_MISC_IRQ_MASK, 8'h01 << i);
            fire(i);
            cmp_bit("int_n", 1'b1, int_n);
        end
        wr(irq_pkg::OFS_SUPPLY_FAULT_MASK, 8'h00);
        supply_in_regulation = 8'hbf;
        repeat (8) @(negedge clk);
        cmp_bit("supply_fault", 1'b1, supply_fault);
        cmp_bit("int_n", 1'b0, int_n);
        chk_rd(irq_pkg::OFS_SUPPLY_IRQ_FLAGS, 8'h40);
        wr(irq_pkg::OFS_SUPPLY_FAULT_MASK, 8'h40);
        cmp_bit("supply_fault", 1'b0, supply_fault);
        supply_in_regulation = 8'hff;
        wr(irq_pkg::OFS_SUPPLY_IRQ_FLAGS, 8'hff);
        cmp_bit("int_n", 1'b0, int_n);
        wr(irq_pkg::OFS_SUPPLY_IRQ_FLAGS, 8'h00);
        cmp_bit("int_n", 1'b1, int_n);
        print_verdict();
    end
endmodule
